// *** hw/msm_midi_scene_mute.sv ***
`include "msm_consts.svh"
`default_nettype none
module msm_midi_scene_mute (
  input  wire logic                 CLOCK,
  input  wire logic                 RSTN,
  input  wire logic                 MIDI_IN,
  output logic                      MIDI_THRU,
  output logic                      MIDI_OUT,
  input  wire logic                 CLEAR_ALL,
  input  wire logic [4:0]           SEND_CH,
  input  wire logic                 SEND_CH_WE,
  input  wire logic [4:0]           RECV_CH,
  input  wire logic                 RECV_CH_WE,
  input  wire logic                 NOTE_EN,
  input  wire logic                 NOTE_EN_WE,
  input  wire msm_pkg::msm_scene_t  SCENE_STEP,
  input  wire msm_pkg::msm_key_t    KEY_PRESS,
  output logic                      TX_READY,
  output msm_pkg::msm_scene_t       SCENE_RECALL,
  output msm_pkg::msm_key_t         MUTE_CMD,
  output logic [4:0]                SEND_CH_STATE,
  output logic [4:0]                RECV_CH_STATE,
  output logic                      NOTE_EN_STATE
);
  import msm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic       in_s1_reg;
  logic       in_s2_reg;
  logic [4:0] send_ch_reg;
  logic [4:0] recv_ch_reg;
  logic       note_en_reg;

  always_ff @(posedge CLOCK) begin
    in_s1_reg <= MIDI_IN;
    in_s2_reg <= in_s1_reg;
  end

  // Thru is a straight wire copy so echo adds no latency and keeps every byte.
  assign MIDI_THRU = MIDI_IN;

  always_ff @(posedge CLOCK) begin
    if (!RSTN || CLEAR_ALL) begin
      send_ch_reg <= `MSM_SEND_DEFAULT;
      recv_ch_reg <= `MSM_CH_OMNI;
      note_en_reg <= 1'b0;
    end else begin
      if (SEND_CH_WE && SEND_CH <= `MSM_CH_OFF) begin
        send_ch_reg <= SEND_CH;
      end
      if (RECV_CH_WE && RECV_CH <= `MSM_CH_OMNI) begin
        recv_ch_reg <= RECV_CH;
      end
      if (NOTE_EN_WE) begin
        note_en_reg <= NOTE_EN;
      end
    end
  end
  assign SEND_CH_STATE = send_ch_reg;
  assign RECV_CH_STATE = recv_ch_reg;
  assign NOTE_EN_STATE = note_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples mid-bit after a falling start edge.
  logic [12:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_busy_reg;
  logic        rx_prev_reg;
  logic        rx_done_reg;
  logic [7:0]  rx_byte_reg;

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rx_cnt_reg  <= 13'h0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 8'h0;
      rx_busy_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
      rx_done_reg <= 1'b0;
      rx_byte_reg <= 8'h0;
    end else begin
      rx_prev_reg <= in_s2_reg;
      rx_done_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (rx_prev_reg && !in_s2_reg) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= 13'(`MSM_HALF_CYC);
          rx_bit_reg  <= 4'h0;
        end
      end else if (rx_cnt_reg != 13'h0) begin
        rx_cnt_reg <= rx_cnt_reg - 13'h1;
      end else begin
        rx_cnt_reg <= 13'(`MSM_BIT_CYC - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && in_s2_reg) begin
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          if (in_s2_reg) begin
            rx_done_reg <= 1'b1;
            rx_byte_reg <= rx_sh_reg;
          end
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {in_s2_reg, rx_sh_reg[7:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message parser with running status.
  logic [3:0] rs_type_reg;
  logic [3:0] rs_chan_reg;
  logic       have_d1_reg;
  logic [6:0] d1_reg;

  function automatic logic chan_match(input logic [4:0] set,
                                      input logic [3:0] ch);
    chan_match = (set == `MSM_CH_OMNI) || (set == {1'b0, ch});
  endfunction

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rs_type_reg  <= 4'h0;
      rs_chan_reg  <= 4'h0;
      have_d1_reg  <= 1'b0;
      d1_reg       <= 7'h0;
      SCENE_RECALL <= '0;
      MUTE_CMD     <= '0;
    end else begin
      SCENE_RECALL.valid <= 1'b0;
      MUTE_CMD.valid     <= 1'b0;
      if (rx_done_reg) begin
        if (rx_byte_reg[7]) begin
          // Realtime bytes leave running status intact.
          if (rx_byte_reg[7:4] != 4'hf) begin
            rs_type_reg <= rx_byte_reg[7:4];
            rs_chan_reg <= rx_byte_reg[3:0];
            have_d1_reg <= 1'b0;
          end else if (rx_byte_reg[3] == 1'b0) begin
            rs_type_reg <= 4'h0;
          end
        end else if (rs_type_reg == `MSM_ST_PROG) begin
          if (chan_match(recv_ch_reg, rs_chan_reg)) begin
            SCENE_RECALL.valid  <= 1'b1;
            SCENE_RECALL.number <= rx_byte_reg[6:0] + 7'h1;
          end
        end else if (rs_type_reg == `MSM_ST_NOTE_ON ||
                     rs_type_reg == `MSM_ST_NOTE_OFF) begin
          if (!have_d1_reg) begin
            have_d1_reg <= 1'b1;
            d1_reg      <= rx_byte_reg[6:0];
          end else begin
            have_d1_reg <= 1'b0;
            if (note_en_reg && chan_match(recv_ch_reg, rs_chan_reg) &&
                d1_reg >= `MSM_NOTE_FIRST && d1_reg <= `MSM_NOTE_LAST &&
                (rx_byte_reg[6:0] == `MSM_VEL_ON ||
                 rx_byte_reg[6:0] == `MSM_VEL_OFF)) begin
              MUTE_CMD.valid   <= 1'b1;
              MUTE_CMD.key     <= 5'(d1_reg - `MSM_NOTE_FIRST);
              MUTE_CMD.mute_on <= (rx_byte_reg[6:0] == `MSM_VEL_ON);
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: queues at most one message of up to three bytes.
  msm_tx_state_t tx_state_reg;
  logic [23:0]   msg_reg;
  logic [1:0]    msg_len_reg;
  logic [1:0]    msg_idx_reg;
  logic          off_pend_reg;
  logic [6:0]    off_note_reg;
  logic [9:0]    bit_idx_reg;
  logic [12:0]   tx_cnt_reg;
  logic [15:0]   gate_cnt_reg;
  logic          tx_line_reg;

  // Off channel blocks sending, so requests are simply consumed.
  assign TX_READY = (tx_state_reg == MSM_TX_IDLE);

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      tx_state_reg <= MSM_TX_IDLE;
      msg_reg      <= 24'h0;
      msg_len_reg  <= 2'h0;
      msg_idx_reg  <= 2'h0;
      off_pend_reg <= 1'b0;
      off_note_reg <= 7'h0;
      bit_idx_reg  <= 10'h0;
      tx_cnt_reg   <= 13'h0;
      gate_cnt_reg <= 16'h0;
      tx_line_reg  <= 1'b1;
    end else begin
      case (tx_state_reg)
        MSM_TX_IDLE: begin
          tx_line_reg <= 1'b1;
          bit_idx_reg <= 10'h0;
          tx_cnt_reg  <= 13'(`MSM_BIT_CYC - 1);
          msg_idx_reg <= 2'h0;
          if (send_ch_reg != `MSM_CH_OFF) begin
            if (SCENE_STEP.valid && SCENE_STEP.number != 7'h0 &&
                SCENE_STEP.number <= `MSM_PROG_MAX + 7'h1) begin
              msg_reg <= {`MSM_ST_PROG, send_ch_reg[3:0],
                          1'b0, 7'(SCENE_STEP.number - 7'h1), 8'h0};
              msg_len_reg  <= 2'h2;
              tx_state_reg <= MSM_TX_SEND;
            end else if (KEY_PRESS.valid &&
                         KEY_PRESS.key < 5'(`MSM_NUM_KEYS)) begin
              msg_reg <= {`MSM_ST_NOTE_ON, send_ch_reg[3:0],
                          1'b0, 7'(`MSM_NOTE_FIRST + 7'(KEY_PRESS.key)),
                          1'b0, KEY_PRESS.mute_on ? `MSM_VEL_ON
                                                  : `MSM_VEL_OFF};
              off_note_reg <= 7'(`MSM_NOTE_FIRST + 7'(KEY_PRESS.key));
              off_pend_reg <= 1'b1;
              msg_len_reg  <= 2'h3;
              tx_state_reg <= MSM_TX_SEND;
            end
          end
        end
        MSM_TX_SEND: begin
          if (tx_cnt_reg != 13'h0) begin
            tx_cnt_reg <= tx_cnt_reg - 13'h1;
          end else begin
            tx_cnt_reg <= 13'(`MSM_BIT_CYC - 1);
            bit_idx_reg <= (bit_idx_reg == 10'h9) ? 10'h0
                                                  : bit_idx_reg + 10'h1;
            if (bit_idx_reg == 10'h9) begin
              msg_reg <= {msg_reg[15:0], 8'h0};
              msg_idx_reg <= msg_idx_reg + 2'h1;
              if (msg_idx_reg + 2'h1 == msg_len_reg) begin
                tx_state_reg <= off_pend_reg ? MSM_TX_GATE : MSM_TX_IDLE;
                gate_cnt_reg <= 16'(`MSM_GATE_CYC - 1);
              end
            end
          end
          case (bit_idx_reg)
            10'h0:   tx_line_reg <= 1'b0;
            10'h9:   tx_line_reg <= 1'b1;
            // The byte on the line sits in the top octet, LSB first.
            default: tx_line_reg <=
                       msg_reg[`MSM_CUR_LSB + 3'(bit_idx_reg - 10'h1)];
          endcase
        end
        MSM_TX_GATE: begin
          tx_line_reg <= 1'b1;
          if (gate_cnt_reg != 16'h0) begin
            gate_cnt_reg <= gate_cnt_reg - 16'h1;
          end else begin
            msg_reg <= {`MSM_ST_NOTE_OFF, send_ch_reg[3:0],
                        1'b0, off_note_reg, 1'b0, `MSM_VEL_OFF};
            msg_len_reg  <= 2'h3;
            msg_idx_reg  <= 2'h0;
            off_pend_reg <= 1'b0;
            bit_idx_reg  <= 10'h0;
            tx_cnt_reg   <= 13'(`MSM_BIT_CYC - 1);
            tx_state_reg <= MSM_TX_SEND;
          end
        end
        default: tx_state_reg <= MSM_TX_IDLE;
      endcase
    end
  end
  assign MIDI_OUT = tx_line_reg;
endmodule
`default_nettype wire

// *** shared/msm_consts.svh ***
`ifndef MSM_CONSTS_SVH
`define MSM_CONSTS_SVH
`define MSM_CLK_HZ        100000000
`define MSM_BAUD          31250
`define MSM_BIT_CYC       (`MSM_CLK_HZ / `MSM_BAUD)
`define MSM_HALF_CYC      (`MSM_BIT_CYC / 2)
`define MSM_GATE_US       2
`define MSM_GATE_CYC      (`MSM_GATE_US * (`MSM_CLK_HZ / 1000000))
`define MSM_ST_PROG       4'hc
`define MSM_ST_NOTE_ON    4'h9
`define MSM_ST_NOTE_OFF   4'h8
`define MSM_NOTE_FIRST    7'h24
`define MSM_NOTE_LAST     7'h35
`define MSM_VEL_ON        7'h60
`define MSM_VEL_OFF       7'h20
`define MSM_PROG_MAX      7'h62
`define MSM_CH_OFF        5'h10
`define MSM_CH_OMNI       5'h11
`define MSM_SEND_DEFAULT  5'h00
`define MSM_NUM_KEYS      18
`define MSM_CUR_LSB       16
`endif

// *** shared/msm_pkg.sv ***
`default_nettype none
package msm_pkg;
  typedef struct packed {
    logic       valid;
    logic [6:0] number;
  } msm_scene_t;
  typedef struct packed {
    logic       valid;
    logic [4:0] key;
    logic       mute_on;
  } msm_key_t;
  typedef enum logic [1:0] {
    MSM_TX_IDLE,
    MSM_TX_SEND,
    MSM_TX_GATE
  } msm_tx_state_t;
endpackage
`default_nettype wire

// *** tb/msm_midi_scene_mute_sva.sv ***
`default_nettype none
module msm_chk (
  input wire logic                CLOCK,
  input wire logic                RSTN,
  input wire logic                MIDI_IN,
  input wire logic                MIDI_THRU,
  input wire logic                MIDI_OUT,
  input wire logic                CLEAR_ALL,
  input wire msm_pkg::msm_scene_t SCENE_STEP,
  input wire msm_pkg::msm_key_t   KEY_PRESS,
  input wire logic                TX_READY,
  input wire msm_pkg::msm_scene_t SCENE_RECALL,
  input wire msm_pkg::msm_key_t   MUTE_CMD,
  input wire logic [4:0]          SEND_CH_STATE,
  input wire logic [4:0]          RECV_CH_STATE,
  input wire logic                NOTE_EN_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  import msm_pkg::*;
  localparam int BIT_CYC = 3200;
  int low_run_reg;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // A low run on the output only ever ends inside a frame, so it is whole bits.
  always_ff @(posedge CLOCK) begin
    low_run_reg <= (!RSTN || MIDI_OUT) ? 0 : low_run_reg + 1;
  end
  sequence s_take;
    SCENE_STEP.valid && TX_READY && SEND_CH_STATE != 5'h10 &&
      SCENE_STEP.number inside {[7'h01:7'h63]};
  endsequence
  sequence s_key_take;
    KEY_PRESS.valid && !SCENE_STEP.valid && TX_READY &&
      SEND_CH_STATE != 5'h10 && KEY_PRESS.key < 5'd18;
  endsequence
  // The take edge leaves the line idle; the start bit follows one edge later.
  sequence s_start;
    !TX_READY ##1 !MIDI_OUT;
  endsequence
  a_thru_copy: assert property (MIDI_THRU == MIDI_IN)
    else $error("thru differs from input");
  a_idle_high: assert property (TX_READY |-> MIDI_OUT)
    else $error("output low while idle");
  a_start_bit: assert property (s_take |=> s_start)
    else $error("no start bit after scene step");
  a_key_start: assert property (s_key_take |=> s_start)
    else $error("no start bit after key press");
  a_bit_timing: assert property ($rose(MIDI_OUT) |->
    low_run_reg != 0 && low_run_reg % BIT_CYC == 0)
    else $error("low run not whole bits");
  a_recall_pulse: assert property (
    SCENE_RECALL.valid |=> !SCENE_RECALL.valid)
    else $error("recall longer than one cycle");
  a_recall_off: assert property (
    SCENE_RECALL.valid |-> $past(RECV_CH_STATE) != 5'h10)
    else $error("recall while receive off");
  a_mute_gate: assert property (MUTE_CMD.valid |->
    MUTE_CMD.key < 5'd18 && $past(NOTE_EN_STATE))
    else $error("bad mute command");
  a_clear_values: assert property (CLEAR_ALL |=>
    SEND_CH_STATE == 5'h00 && RECV_CH_STATE == 5'h11 && !NOTE_EN_STATE)
    else $error("clear-all values wrong");
  a_chan_range: assert property (
    SEND_CH_STATE <= 5'h10 && RECV_CH_STATE <= 5'h11)
    else $error("channel setting out of range");
  a_off_drops: assert property (
    (SCENE_STEP.valid || KEY_PRESS.valid) && TX_READY &&
      SEND_CH_STATE == 5'h10 |=> (TX_READY && MIDI_OUT) [*3])
    else $error("send off but transmitted");
endmodule
bind msm_midi_scene_mute msm_chk msm_chk_inst (.CLOCK, .RSTN, .MIDI_IN,
  .MIDI_THRU, .MIDI_OUT, .CLEAR_ALL, .SCENE_STEP, .KEY_PRESS, .TX_READY,
  .SCENE_RECALL, .MUTE_CMD, .SEND_CH_STATE, .RECV_CH_STATE, .NOTE_EN_STATE);
`default_nettype wire

// *** tb/msm_midi_peer.sv ***
`default_nettype none
module msm_midi_peer (
  input  wire logic  clock,
  input  wire logic  from_dev,
  output logic       to_dev,
  output logic [7:0] rx_byte,
  output logic       rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 3200;
  initial begin
    to_dev = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      to_dev <= f[i];
      repeat (BIT_CYC) @(posedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Bytes with a bad stop bit are not reported, so the bench sees them missing.
  always begin
    @(negedge from_dev);
    repeat (BIT_CYC / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clock);
      rx_byte[i] = from_dev;
    end
    repeat (BIT_CYC) @(posedge clock);
    if (from_dev) begin
      rx_valid <= 1'b1;
      @(posedge clock);
      rx_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msm_pkg::*;
  logic       clock, rstn, midi_in, midi_thru, midi_out, clear_all, tx_ready;
  logic [4:0] send_ch, recv_ch, send_st, recv_st;
  logic       send_we, recv_we, note_en, note_we, note_st, rx_valid;
  logic [7:0] rx_byte, exp_b, exp_tx[$];
  logic [6:0] prog, scene, exp_r, exp_scene[$];
  msm_scene_t step, recall;
  msm_key_t   key, mute;
  int         fails = 0;
  int         total_checks = 0;
  msm_midi_scene_mute msm_midi_scene_mute_inst (.CLOCK(clock), .RSTN(rstn),
    .MIDI_IN(midi_in), .MIDI_THRU(midi_thru), .MIDI_OUT(midi_out),
    .CLEAR_ALL(clear_all), .SEND_CH(send_ch), .SEND_CH_WE(send_we),
    .RECV_CH(recv_ch), .RECV_CH_WE(recv_we), .NOTE_EN(note_en),
    .NOTE_EN_WE(note_we), .SCENE_STEP(step), .KEY_PRESS(key),
    .TX_READY(tx_ready), .SCENE_RECALL(recall), .MUTE_CMD(mute),
    .SEND_CH_STATE(send_st), .RECV_CH_STATE(recv_st), .NOTE_EN_STATE(note_st));
  msm_midi_peer msm_midi_peer_inst (.clock(clock), .from_dev(midi_out),
    .to_dev(midi_in), .rx_byte(rx_byte), .rx_valid(rx_valid));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk_set(logic [4:0] s, logic [4:0] r, logic n);
    #1;
    check("send_ch", 8'(s), 8'(send_st));
    check("recv_ch", 8'(r), 8'(recv_st));
    check("note_en", 8'(n), 8'(note_st));
    @(posedge clock);
  endtask
  task automatic set_all(logic [4:0] s, logic [4:0] r, logic n);
    send_ch <= s;
    recv_ch <= r;
    note_en <= n;
    {send_we, recv_we, note_we} <= 3'b111;
    @(posedge clock);
    {send_we, recv_we, note_we} <= 3'b000;
    repeat (2) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    // The tests need about 95000 cycles, nearly all of it serial bytes.
    repeat (100000) @(posedge clock);
    fails++;
    results();
  end
  // Results are matched against bytes and scenes queued by the driver, oldest first.
  always @(posedge clock) begin
    if (rx_valid) begin
      exp_b = exp_tx.size() > 0 ? exp_tx.pop_front() : ~rx_byte;
      check("tx_byte", exp_b, rx_byte);
    end
    if (recall.valid === 1'b1) begin
      exp_r = exp_scene.size() > 0 ? exp_scene.pop_front() : ~recall.number;
      check("recall", 8'(exp_r), 8'(recall.number));
    end
    if (mute.valid !== 1'b0) check("mute", 8'h00, 8'(mute));
  end
  initial begin
    {rstn, clear_all, send_we, recv_we, note_we, note_en} = '0;
    {send_ch, recv_ch, step, key} = '0;
    void'($urandom(32'hdb48));
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk_set(5'h00, 5'h11, 1'b0);
    set_all(5'h03, 5'h10, 1'b1);
    chk_set(5'h03, 5'h10, 1'b1);
    set_all(5'h12, 5'h0f, 1'b1);
    chk_set(5'h03, 5'h0f, 1'b1);
    clear_all <= 1'b1;
    @(posedge clock);
    clear_all <= 1'b0;
    @(posedge clock);
    chk_set(5'h00, 5'h11, 1'b0);
    set_all(5'h10, 5'h11, 1'b0);
    step <= {1'b1, 7'h05};
    key <= {1'b1, 5'h02, 1'b1};
    @(posedge clock);
    {step, key} <= '0;
    repeat (3) @(posedge clock);
    #1 check("dropped", 8'h03, {6'h00, tx_ready, midi_out});
    @(posedge clock);
    set_all(5'h00, 5'h11, 1'b0);
    prog = 7'($urandom_range(98, 0));
    scene = 7'($urandom_range(99, 1));
    exp_scene.push_back(prog + 7'h01);
    exp_tx.push_back(8'hc0);
    exp_tx.push_back({1'b0, scene - 7'h01});
    step <= {1'b1, scene};
    @(posedge clock);
    step <= '0;
    msm_midi_peer_inst.send(8'hc7);
    msm_midi_peer_inst.send({1'b0, prog});
    for (int i = 0; i < 9000 && exp_tx.size() + exp_scene.size() > 0; i++)
      @(posedge clock);
    check("pending", 8'h00, 8'(exp_tx.size() + exp_scene.size()));
    set_all(5'h05, 5'h02, 1'b1);
    exp_tx.push_back(8'h95);
    key <= {1'b1, 5'($urandom_range(17, 0)), 1'($urandom_range(1, 0))};
    @(posedge clock);
    key <= '0;
    for (int i = 0; i < 33000 && exp_tx.size() > 0; i++)
      @(posedge clock);
    check("key_pending", 8'h00, 8'(exp_tx.size()));
    // Reset inside the stop bit so the rest of the note is abandoned.
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk_set(5'h00, 5'h11, 1'b0);
    #1 check("reset_idle", 8'h03, {6'h00, tx_ready, midi_out});
    results();
  end
endmodule
`default_nettype wire
